// [lfq_pkg.sv]
// LIN frame queues: register map, item layout, state codes and timing counts.
// Assumes one 100 MHz clock and an APB master with 32-bit data.
package lfq_pkg;
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned INACT_S     = 4;
  localparam logic [28:0] INACT_CYC_D = 29'(64'(INACT_S) * 64'(CLK_HZ));
  localparam int unsigned AW          = 8;
  localparam logic [7:0]  A_CTRL      = 8'h00;
  localparam logic [7:0]  A_BAUD      = 8'h04;
  localparam logic [7:0]  A_RESP      = 8'h08;
  localparam logic [7:0]  A_THR       = 8'h0c;
  localparam logic [7:0]  A_STAT      = 8'h10;
  localparam logic [7:0]  A_TXID      = 8'h14;
  localparam logic [7:0]  A_RXPOP     = 8'h18;
  localparam logic [7:0]  A_RXD0      = 8'h1c;
  localparam logic [7:0]  A_RXD1      = 8'h20;
  localparam int unsigned C_START     = 0;
  localparam int unsigned C_LOG       = 1;
  localparam int unsigned C_ENH       = 2;
  localparam int unsigned C_SLEEP     = 3;
  localparam int unsigned C_WAKE      = 4;
  localparam int unsigned S_PEND      = 0;
  localparam int unsigned S_OVER      = 1;
  localparam int unsigned S_DRAIN     = 2;
  localparam int unsigned S_ERR       = 3;
  localparam int unsigned S_STALE     = 4;
  localparam int unsigned S_SLEEP     = 5;
  localparam int unsigned S_IGN       = 6;
  localparam int unsigned S_CNT       = 8;
  localparam int unsigned F_ID        = 0;
  localparam int unsigned F_LEN       = 8;
  localparam int unsigned F_TYPE      = 16;
  localparam int unsigned F_STALE     = 31;
  localparam logic [1:0]  IT_FULL     = 2'h1;
  localparam logic [1:0]  IT_ERR      = 2'h2;
  localparam logic [1:0]  IT_INACT    = 2'h3;
  localparam logic [7:0]  SYNC        = 8'h55;
  localparam logic [15:0] BAUD_RST    = 16'h1458;
  localparam logic [3:0]  RESP_RST    = 4'h8;
  localparam logic [7:0]  THR_RST     = 8'h00;
  localparam logic [3:0]  BRK_TX      = 4'hd;
  localparam logic [3:0]  BRK_RX      = 4'hb;
  localparam logic [3:0]  WAKE_BITS   = 4'h5;
  localparam logic [3:0]  HDR_TO      = 4'he;

  typedef enum logic [3:0] {R_IDLE = 4'h1, R_BRK = 4'h2, R_WAIT = 4'h4, R_BIT = 4'h8} lfq_rx_t;
  typedef enum logic [3:0] {T_IDLE = 4'h1, T_BRK = 4'h2, T_DEL = 4'h4, T_BYTE = 4'h8} lfq_tx_t;
endpackage : lfq_pkg

// [lfq_props.sv]
// Port checker for lfq_top.
// Sees only lfq_top ports; bound below.
`timescale 1ns/1ps
module lfq_props
import lfq_pkg::*;
(
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          lin_out,
  input wire logic          lin_oe_n,
  input wire logic          read_items_pending,
  input wire logic          queue_depth_over_threshold,
  input wire logic          transmit_queue_drained
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr_tx = psel && penable && pwrite && paddr == A_TXID;
  wire pop   = psel && penable && !pwrite && paddr == A_RXPOP;
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable && pready; endsequence
  a_ready_setup: assert property (s_setup |=> s_access) else $error("no ready after setup");
  a_ready_idle: assert property (!psel |=> !pready) else $error("ready while idle");
  a_slverr_ready: assert property (pslverr |-> pready) else $error("error outside access");
  a_data_low: assert property (!lin_out) else $error("data pin not low");
  a_break_min: assert property ($fell(lin_oe_n) |-> !lin_oe_n[*8]) else $error("short low");
  a_drain_fall: assert property ($fell(transmit_queue_drained) |-> $past(wr_tx) || $past(wr_tx, 2))
    else $error("drained fell without write");
  a_pend_fall: assert property ($fell(read_items_pending) |-> $past(pop) || $past(pop, 2))
    else $error("pending fell without pop");
  a_over_pend: assert property ($rose(queue_depth_over_threshold) |-> ##[0:2] read_items_pending)
    else $error("depth flag with empty queue");
endmodule : lfq_props

bind lfq_top lfq_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr), .lin_out(lin_out), .lin_oe_n(lin_oe_n),
  .read_items_pending(read_items_pending), .queue_depth_over_threshold(queue_depth_over_threshold),
  .transmit_queue_drained(transmit_queue_drained));

// [lfq_slave_model.sv]
// LIN slave model answering each header with one byte and a checksum, and the bench.
// Assumes the bus is a wired AND with a pull-up and one data byte per frame.
`timescale 1ns/1ps
module lfq_slave_model
#(parameter int BIT = 16)
(
  input  wire logic       pclk,
  input  wire logic       lin_bus,
  input  wire logic [7:0] resp_byte,
  input  wire logic       bad_sum,
  output logic            slave_oe_n
);
  int low = 0;
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
      repeat (BIT) @(posedge pclk) slave_oe_n <= f[i];
  endtask : send
  initial
  begin
    slave_oe_n = 1'b1;
    forever
    begin
      @(posedge pclk);
      if (!lin_bus)
        low++;
      else if (low < 11 * BIT)
        low = 0;
      else
      begin
        // Break seen: skip delimiter, sync and identifier, then answer
        low = 0;
        repeat (21 * BIT) @(posedge pclk);
        send(resp_byte);
        send(bad_sum ? resp_byte : ~resp_byte);
      end
    end
  end
endmodule : lfq_slave_model

module lfq_top_tb;
  import lfq_pkg::*;
  logic          pclk, presetn, psel, penable, pwrite, bad_sum, err;
  logic [AW-1:0] paddr;
  logic [31:0]   pwdata, prdata, rdv;
  logic          pready, pslverr, lin_out, lin_oe_n, slave_oe_n;
  logic          pend, over, drained;
  logic [7:0]    rbyte;
  logic [5:0]    id, id2;
  int            miscompares = 0;
  int            samples_checked = 0;
  int            seed = 34;
  wire           lin_bus = lin_oe_n & slave_oe_n;

  lfq_top #(.RX_DEPTH(8), .TX_DEPTH(4), .INACT_CYC(29'h7d0)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lin_rx(lin_bus), .lin_out(lin_out), .lin_oe_n(lin_oe_n),
    .read_items_pending(pend), .queue_depth_over_threshold(over), .transmit_queue_drained(drained));
  lfq_slave_model #(.BIT(16)) i_slave (.pclk(pclk), .lin_bus(lin_bus), .resp_byte(rbyte), .bad_sum(bad_sum),
    .slave_oe_n(slave_oe_n));

  function automatic logic [31:0] exp_info(input logic [1:0] ty, input logic [3:0] len, input logic [5:0] fid);
    return (32'(ty) << F_TYPE) | (32'(len) << F_LEN) | (32'(fid) << F_ID);
  endfunction : exp_info

  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (!pready)
      @(posedge pclk);
    rdv = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic frame(input logic bad);
    id       = 6'($random(seed));
    rbyte   <= 8'($random(seed));
    bad_sum <= bad;
    apb(1'b1, A_TXID, {26'h0, id});
    @(posedge pclk);
    check("drained_fall", {31'h0, drained}, 32'h0);
    while (!pend)
      @(posedge pclk);
    apb(1'b0, A_RXPOP, 32'h0);
    check("item", rdv, exp_info(bad ? IT_ERR : IT_FULL, bad ? 4'h3 : 4'h1, id));
    apb(1'b0, A_RXD0, 32'h0);
    check("item_data", rdv, {24'h0, rbyte});
  endtask : frame

  initial
  begin
    pclk = 1'b0;
    forever
      #5 pclk = ~pclk;
  end

  initial
  begin
    #600000;
    miscompares++;
    finish_test();
  end

  initial
  begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
    rbyte   = 8'h00;
    bad_sum = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("drained_rst", {31'h0, drained}, 32'h1);
    check("pend_rst", {31'h0, pend}, 32'h0);
    check("data_pin", {31'h0, lin_out}, 32'h0);
    apb(1'b0, A_RXPOP, 32'h0);
    check("empty_pop", rdv, 32'h8000_0000);
    apb(1'b0, A_RXD1, 32'h0);
    check("empty_data", rdv, 32'h0);
    apb(1'b0, 8'h3c, 32'h0);
    check("slverr", {31'h0, err}, 32'h1);
    $display("test reset done");
    apb(1'b1, A_BAUD, 32'h10);
    apb(1'b1, A_RESP, 32'h1);
    apb(1'b1, A_THR, 32'h1);
    apb(1'b1, A_CTRL, 32'h3);
    check("drained_start", {31'h0, drained}, 32'h1);
    frame(1'b0);
    frame(1'b1);
    $display("test frames done");
    bad_sum <= 1'b0;
    id       = 6'($random(seed));
    id2      = id ^ 6'h2a;
    apb(1'b1, A_TXID, {26'h0, id});
    apb(1'b1, A_TXID, {26'h0, id2});
    @(posedge pclk);
    while (!drained)
      @(posedge pclk);
    repeat (600) @(posedge pclk);
    check("depth_rise", {31'h0, over}, 32'h1);
    apb(1'b0, A_RXPOP, 32'h0);
    check("first", rdv, exp_info(IT_FULL, 4'h1, id));
    repeat (2) @(posedge pclk);
    check("depth_fall", {31'h0, over}, 32'h0);
    apb(1'b0, A_RXPOP, 32'h0);
    check("second", rdv, exp_info(IT_FULL, 4'h1, id2));
    repeat (2) @(posedge pclk);
    check("pend_fall", {31'h0, pend}, 32'h0);
    apb(1'b0, A_RXPOP, 32'h0);
    check("stale", rdv, exp_info(IT_FULL, 4'h1, id2) | 32'h8000_0000);
    $display("test order done");
    apb(1'b1, A_CTRL, 32'hb);
    apb(1'b0, A_STAT, 32'h0);
    check("asleep", {31'h0, rdv[S_SLEEP]}, 32'h1);
    apb(1'b1, A_CTRL, 32'h1b);
    repeat (200) @(posedge pclk);
    apb(1'b0, A_STAT, 32'h0);
    check("awake", {31'h0, rdv[S_SLEEP]}, 32'h0);
    while (!pend)
      @(posedge pclk);
    apb(1'b0, A_RXPOP, 32'h0);
    check("inactive", rdv, exp_info(IT_INACT, 4'h0, 6'h00));
    apb(1'b0, A_STAT, 32'h0);
    check("ignoring", {31'h0, rdv[S_IGN]}, 32'h1);
    $display("test sleep done");
    apb(1'b1, A_CTRL, 32'h0);
    repeat (5) apb(1'b1, A_TXID, 32'h0);
    apb(1'b0, A_STAT, 32'h0);
    check("overflow", {31'h0, rdv[S_ERR]}, 32'h1);
    $display("test overflow done");
    finish_test();
  end
endmodule : lfq_top_tb

// [lfq_top.sv]
// LIN frame queues: APB registers, receive and transmit queues, LIN engines.
// Assumes lin_rx is asynchronous to pclk and the LIN pin is open drain.
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module lfq_top
#(
  parameter int unsigned RX_DEPTH  = 8,
  parameter int unsigned TX_DEPTH  = 4,
  parameter logic [28:0] INACT_CYC = lfq_pkg::INACT_CYC_D
)
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [lfq_pkg::AW-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   lin_rx,
  output logic                        lin_out,
  output logic                        lin_oe_n,
  output logic                        read_items_pending,
  output logic                        queue_depth_over_threshold,
  output logic                        transmit_queue_drained
);
  import lfq_pkg::*;

  localparam int unsigned RXN = (RX_DEPTH == 0) ? 1 : RX_DEPTH;
  localparam int unsigned TXN = (TX_DEPTH == 0) ? 1 : TX_DEPTH;
  localparam int unsigned RPW = (RXN > 1) ? $clog2(RXN) : 1;
  localparam int unsigned TPW = (TXN > 1) ? $clog2(TXN) : 1;
  localparam int unsigned RCW = $clog2(RXN + 1);
  localparam int unsigned TCW = $clog2(TXN + 1);
  localparam logic [RCW-1:0] RX_FULL = RCW'(RXN);
  localparam logic [TCW-1:0] TX_FULL = TCW'(TXN);
  localparam logic [RPW-1:0] RX_LAST = RPW'(RXN - 1);
  localparam logic [TPW-1:0] TX_LAST = TPW'(TXN - 1);

  function automatic logic [19:0] bt(input logic [15:0] div, input logic [3:0] n);
    return {4'h0, div} * {16'h0000, n};
  endfunction : bt

  function automatic logic [7:0] csum_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[7:0] + {7'h00, s[8]};
  endfunction : csum_add

  function automatic logic [7:0] pid_of(input logic [5:0] id);
    return {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
  endfunction : pid_of

  function automatic logic [31:0] mk_info(input logic [1:0] ty, input logic [3:0] len,
                                          input logic [5:0] id);
    logic [31:0] w;
    w = '0;
    w[F_TYPE +: 2] = ty;
    w[F_LEN +: 4]  = len;
    w[F_ID +: 6]   = id;
    return w;
  endfunction : mk_info

  logic            pready_q, pslverr_q, pop_ok_q;
  logic [31:0]     prdata_q, rd_val;
  logic            addr_ok, setup, wr, rd, ctrl_wr, start_set;
  logic            start_q, log_q, enh_q, sleep_q, wreq_q, run, wake_go;
  logic [15:0]     baud_q;
  logic [3:0]      resp_q;
  logic [7:0]      thr_q;
  logic            rxs1_q, rxs2_q, rxs3_q;
  logic [28:0]     quiet_q;
  logic            inact_q, ign_q, sync_ok_q;
  lfq_rx_t         rst_q;
  logic [19:0]     rtm_q;
  logic [3:0]      rbit_q, rfld_q;
  logic [7:0]      rsh_q, rcs_q;
  logic [5:0]      rid_q;
  logic [63:0]     rdat_q, rq_dat_q, last_dat_q;
  logic            rq_push_q, rx_put, rx_pop, stale_q, pend_q, over_q;
  logic [31:0]     rq_info_q, last_info_q;
  logic [31:0]     rq_info [RXN];
  logic [63:0]     rq_dat  [RXN];
  logic [RPW-1:0]  rx_wp_q, rx_rp_q;
  logic [RCW-1:0]  rx_cnt_q;
  logic [5:0]      tq [TXN];
  logic [TPW-1:0]  tx_wp_q, tx_rp_q;
  logic [TCW-1:0]  tx_cnt_q;
  logic            tx_wr, tx_put, tx_pop, err_q, drained_q;
  lfq_tx_t         tst_q;
  logic [19:0]     ttm_q;
  logic [3:0]      tbit_q;
  logic [9:0]      tsh_q;
  logic            tsel_q, twake_q, oe_n_q, out_q, tx_done_q, wake_done_q;

  assign prdata                     = prdata_q;
  assign pready                     = pready_q;
  assign pslverr                    = pslverr_q;
  assign lin_out                    = out_q;
  assign lin_oe_n                   = oe_n_q;
  assign read_items_pending         = pend_q;
  assign queue_depth_over_threshold = over_q;
  assign transmit_queue_drained     = drained_q;

  // APB: one wait-free access phase, side effects at its completing edge
  assign setup     = psel & ~penable;
  assign wr        = psel & penable & pready_q & pwrite;
  assign rd        = psel & penable & pready_q & ~pwrite;
  assign ctrl_wr   = wr && (paddr == A_CTRL);
  assign start_set = ctrl_wr && pwdata[C_START] && !start_q;
  assign run       = start_q & ~sleep_q;
  assign wake_go   = (tst_q == T_IDLE) && sleep_q && wreq_q;

  always_comb
  begin
    rd_val  = '0;
    addr_ok = 1'b1;
    if (paddr == A_CTRL)
    begin
      rd_val[C_START] = start_q;
      rd_val[C_LOG]   = log_q;
      rd_val[C_ENH]   = enh_q;
      rd_val[C_SLEEP] = sleep_q;
      rd_val[C_WAKE]  = wreq_q;
    end
    else if (paddr == A_BAUD)
      rd_val[15:0] = baud_q;
    else if (paddr == A_RESP)
      rd_val[3:0] = resp_q;
    else if (paddr == A_THR)
      rd_val[7:0] = thr_q;
    else if (paddr == A_STAT)
    begin
      rd_val[S_PEND]        = pend_q;
      rd_val[S_OVER]        = over_q;
      rd_val[S_DRAIN]       = drained_q;
      rd_val[S_ERR]         = err_q;
      rd_val[S_STALE]       = stale_q;
      rd_val[S_SLEEP]       = sleep_q;
      rd_val[S_IGN]         = ign_q;
      rd_val[S_CNT +: RCW]  = rx_cnt_q;
    end
    else if (paddr == A_RXPOP)
    begin
      if (rx_cnt_q != '0)
        rd_val = rq_info[rx_rp_q];
      else
      begin
        rd_val          = last_info_q;
        rd_val[F_STALE] = 1'b1;
      end
    end
    else if (paddr == A_RXD0)
      rd_val = last_dat_q[31:0];
    else if (paddr == A_RXD1)
      rd_val = last_dat_q[63:32];
    else if (paddr != A_TXID)
      addr_ok = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      pop_ok_q  <= 1'b0;
      prdata_q  <= '0;
    end
    else
    begin
      pready_q  <= setup;
      // Error stands only in the access cycle
      pslverr_q <= setup & ~addr_ok;
      // Pop only what the setup cycle returned, never a later arrival
      pop_ok_q  <= setup && (rx_cnt_q != '0);
      if (setup)
        prdata_q <= pwrite ? 32'h0000_0000 : rd_val;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      start_q <= 1'b0;
      log_q   <= 1'b0;
      enh_q   <= 1'b0;
      baud_q  <= BAUD_RST;
      resp_q  <= RESP_RST;
      thr_q   <= THR_RST;
    end
    else if (ctrl_wr)
    begin
      start_q <= pwdata[C_START];
      log_q   <= pwdata[C_LOG];
      enh_q   <= pwdata[C_ENH];
    end
    else if (wr && paddr == A_BAUD)
      baud_q <= pwdata[15:0];
    else if (wr && paddr == A_RESP)
      resp_q <= pwdata[3:0];
    else if (wr && paddr == A_THR)
      thr_q <= pwdata[7:0];
  end

  // Sleep state: software enters it, bus activity or own wake pulse leaves it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sleep_q <= 1'b0;
      wreq_q  <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      sleep_q <= pwdata[C_SLEEP];
      wreq_q  <= pwdata[C_WAKE];
    end
    else if (sleep_q && (!rxs2_q || wake_done_q))
    begin
      sleep_q <= 1'b0;
      wreq_q  <= 1'b0;
    end
    else if (wake_go)
      wreq_q <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rxs1_q <= 1'b1;
      rxs2_q <= 1'b1;
      rxs3_q <= 1'b1;
    end
    else
    begin
      rxs1_q <= lin_rx;
      rxs2_q <= rxs1_q;
      rxs3_q <= rxs2_q;
    end
  end

  // Bus quiet timer, fires once per quiet stretch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      quiet_q <= '0;
      inact_q <= 1'b0;
    end
    else
    begin
      inact_q <= 1'b0;
      if (!start_q || !rxs2_q || rxs2_q != rxs3_q)
        quiet_q <= '0;
      else if (quiet_q != INACT_CYC)
      begin
        quiet_q <= quiet_q + 29'h1;
        inact_q <= (quiet_q == INACT_CYC - 29'h1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ign_q <= 1'b0;
    else if (sync_ok_q)
      ign_q <= 1'b0;
    else if (inact_q && !sleep_q)
      ign_q <= 1'b1;
  end

  // Receiver: break, sync, protected id, response bytes, checksum
  always_ff @(posedge pclk or negedge presetn)
  begin : rx_fsm
    logic       err;
    logic [2:0] bidx;
    err  = 1'b0;
    bidx = 3'(rfld_q - 4'h2);
    if (!presetn)
    begin
      rst_q     <= R_IDLE;
      rtm_q     <= '0;
      rbit_q    <= '0;
      rsh_q     <= '0;
      rfld_q    <= '0;
      rid_q     <= '0;
      rcs_q     <= '0;
      rdat_q    <= '0;
      rq_push_q <= 1'b0;
      rq_info_q <= '0;
      rq_dat_q  <= '0;
      sync_ok_q <= 1'b0;
    end
    else
    begin
      rq_push_q <= 1'b0;
      sync_ok_q <= 1'b0;
      case (rst_q)
        R_IDLE:
          if (run && !rxs2_q)
          begin
            rst_q <= R_BRK;
            rtm_q <= '0;
          end
        R_BRK:
          begin
            rtm_q <= rtm_q + 20'h1;
            if (rxs2_q)
            begin
              // Short low pulses such as wake-ups are dropped here
              rst_q  <= (rtm_q >= bt(baud_q, BRK_RX)) ? R_WAIT : R_IDLE;
              rtm_q  <= '0;
              rfld_q <= '0;
              rdat_q <= '0;
              rid_q  <= '0;
            end
          end
        R_WAIT:
          begin
            rtm_q <= rtm_q + 20'h1;
            if (!rxs2_q)
            begin
              rst_q  <= R_BIT;
              rtm_q  <= {5'h00, baud_q[15:1]};
              rbit_q <= '0;
            end
            else if (rtm_q >= bt(baud_q, HDR_TO))
              err = 1'b1;
          end
        R_BIT:
          if (rtm_q != '0)
            rtm_q <= rtm_q - 20'h1;
          else
          begin
            rtm_q  <= {4'h0, baud_q} - 20'h1;
            rbit_q <= rbit_q + 4'h1;
            if (rbit_q == 4'h0)
              err = rxs2_q;
            else if (rbit_q != 4'h9)
              rsh_q <= {rxs2_q, rsh_q[7:1]};
            else if (!rxs2_q)
              err = 1'b1;
            else
            begin
              rst_q  <= R_WAIT;
              rtm_q  <= '0;
              rfld_q <= rfld_q + 4'h1;
              if (rfld_q == 4'h0)
              begin
                err       = (rsh_q != SYNC);
                sync_ok_q <= (rsh_q == SYNC);
              end
              else if (rfld_q == 4'h1)
              begin
                err   = (rsh_q != pid_of(rsh_q[5:0]));
                rid_q <= rsh_q[5:0];
                rcs_q <= enh_q ? rsh_q : 8'h00;
              end
              else if ({1'b0, rfld_q} < {1'b0, resp_q} + 5'h02)
              begin
                rdat_q[{bidx, 3'h0} +: 8] <= rsh_q;
                rcs_q                     <= csum_add(rcs_q, rsh_q);
              end
              else
              begin
                err   = (rsh_q != ~rcs_q);
                rst_q <= R_IDLE;
                if (!err)
                begin
                  // Sleep requests land here as ordinary frames
                  rq_push_q <= 1'b1;
                  rq_info_q <= mk_info(IT_FULL, resp_q, rid_q);
                  rq_dat_q  <= rdat_q;
                end
              end
            end
          end
        default:
          rst_q <= R_IDLE;
      endcase
      if (err)
      begin
        rst_q <= R_IDLE;
        if (log_q && !ign_q)
        begin
          rq_push_q <= 1'b1;
          rq_info_q <= mk_info(IT_ERR, rfld_q, rid_q);
          rq_dat_q  <= rdat_q;
        end
      end
      else if (inact_q)
      begin
        rq_push_q <= 1'b1;
        rq_info_q <= mk_info(IT_INACT, 4'h0, 6'h00);
        rq_dat_q  <= '0;
      end
    end
  end

  // Receive queue; with zero depth the single slot is overwritten silently
  assign rx_pop = rd && (paddr == A_RXPOP) && pop_ok_q;
  assign rx_put = rq_push_q && (RX_DEPTH == 0 || rx_cnt_q != RX_FULL || rx_pop);

  always_ff @(posedge pclk)
  begin
    if (rx_put)
    begin
      rq_info[rx_wp_q] <= rq_info_q;
      rq_dat[rx_wp_q]  <= rq_dat_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_wp_q  <= '0;
      rx_rp_q  <= '0;
      rx_cnt_q <= '0;
    end
    else
    begin
      if (rx_put)
        rx_wp_q <= (rx_wp_q == RX_LAST) ? '0 : rx_wp_q + 1'b1;
      if (rx_pop)
        rx_rp_q <= (rx_rp_q == RX_LAST) ? '0 : rx_rp_q + 1'b1;
      if (rx_put && !rx_pop && rx_cnt_q != RX_FULL)
        rx_cnt_q <= rx_cnt_q + 1'b1;
      else if (rx_pop && !rx_put)
        rx_cnt_q <= rx_cnt_q - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_info_q <= '0;
      last_dat_q  <= '0;
      stale_q     <= 1'b0;
    end
    else if (rd && paddr == A_RXPOP)
    begin
      if (rx_pop)
      begin
        last_info_q <= rq_info[rx_rp_q];
        last_dat_q  <= rq_dat[rx_rp_q];
        stale_q     <= 1'b0;
      end
      else
        stale_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_q <= 1'b0;
      over_q <= 1'b0;
    end
    else
    begin
      pend_q <= (rx_cnt_q != '0);
      over_q <= (32'(rx_cnt_q) > 32'(thr_q));
    end
  end

  // Transmit queue of header identifiers
  assign tx_wr  = wr && (paddr == A_TXID);
  assign tx_put = tx_wr && (TX_DEPTH == 0 || tx_cnt_q != TX_FULL);
  assign tx_pop = tx_done_q && (tx_cnt_q != '0);

  always_ff @(posedge pclk)
  begin
    if (tx_put)
      tq[tx_wp_q] <= pwdata[5:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_wp_q  <= '0;
      tx_rp_q  <= '0;
      tx_cnt_q <= '0;
    end
    else
    begin
      if (tx_put)
        tx_wp_q <= (tx_wp_q == TX_LAST) ? '0 : tx_wp_q + 1'b1;
      if (tx_pop)
        tx_rp_q <= (tx_rp_q == TX_LAST) ? '0 : tx_rp_q + 1'b1;
      if (tx_put && !tx_pop && tx_cnt_q != TX_FULL)
        tx_cnt_q <= tx_cnt_q + 1'b1;
      else if (tx_pop && !tx_put)
        tx_cnt_q <= tx_cnt_q - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      err_q <= 1'b0;
    else if (tx_wr && !tx_put)
      err_q <= 1'b1;
    else if (wr && paddr == A_STAT && pwdata[S_ERR])
      err_q <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      drained_q <= 1'b1;
    else if (tx_put)
      drained_q <= 1'b0;
    else if (start_set || (tx_done_q && tx_cnt_q == TCW'(1)))
      drained_q <= 1'b1;
  end

  // Transmitter: master header or wake pulse, open drain
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tst_q       <= T_IDLE;
      ttm_q       <= '0;
      tbit_q      <= '0;
      tsh_q       <= '0;
      tsel_q      <= 1'b0;
      twake_q     <= 1'b0;
      oe_n_q      <= 1'b1;
      out_q       <= 1'b0;
      tx_done_q   <= 1'b0;
      wake_done_q <= 1'b0;
    end
    else
    begin
      out_q       <= 1'b0;
      tx_done_q   <= 1'b0;
      wake_done_q <= 1'b0;
      case (tst_q)
        T_IDLE:
          if (wake_go)
          begin
            tst_q   <= T_BRK;
            twake_q <= 1'b1;
            oe_n_q  <= 1'b0;
            ttm_q   <= bt(baud_q, WAKE_BITS) - 20'h1;
          end
          else if (run && tx_cnt_q != '0 && rst_q == R_IDLE && rxs2_q)
          begin
            tst_q   <= T_BRK;
            twake_q <= 1'b0;
            oe_n_q  <= 1'b0;
            ttm_q   <= bt(baud_q, BRK_TX) - 20'h1;
          end
        T_BRK:
          if (ttm_q != '0)
            ttm_q <= ttm_q - 20'h1;
          else
          begin
            oe_n_q      <= 1'b1;
            ttm_q       <= {4'h0, baud_q} - 20'h1;
            wake_done_q <= twake_q;
            tst_q       <= twake_q ? T_IDLE : T_DEL;
          end
        T_DEL:
          if (ttm_q != '0)
            ttm_q <= ttm_q - 20'h1;
          else
          begin
            tst_q  <= T_BYTE;
            tsh_q  <= {1'b1, SYNC, 1'b0};
            tsel_q <= 1'b0;
            tbit_q <= '0;
            oe_n_q <= 1'b0;
            ttm_q  <= {4'h0, baud_q} - 20'h1;
          end
        T_BYTE:
          if (ttm_q != '0)
            ttm_q <= ttm_q - 20'h1;
          else
          begin
            ttm_q <= {4'h0, baud_q} - 20'h1;
            if (tbit_q != 4'h9)
            begin
              tsh_q  <= {1'b1, tsh_q[9:1]};
              tbit_q <= tbit_q + 4'h1;
              oe_n_q <= tsh_q[1];
            end
            else if (!tsel_q)
            begin
              tsh_q  <= {1'b1, pid_of(tq[tx_rp_q]), 1'b0};
              tsel_q <= 1'b1;
              tbit_q <= '0;
              oe_n_q <= 1'b0;
            end
            else
            begin
              tst_q     <= T_IDLE;
              tx_done_q <= 1'b1;
            end
          end
        default:
          tst_q <= T_IDLE;
      endcase
    end
  end
endmodule : lfq_top
